/* File: bench/lcsr_host.sv */
`timescale 1ns/1ps
module lcsr_host (
    input wire logic sys_clk,
    input wire logic spi_miso,
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_mosi,
    output logic [7:0] rd_data,
    output logic rd_done
);
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
        rd_data = 8'h00;
        rd_done = 1'b0;
    end
    // ==========================================
    // one frame, entered just after a falling edge
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat);
        logic [15:0] sh;
        logic [15:0] rd;
        sh = {cmd, dat};
        spi_cs_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        for (int i = 15; i >= 0; i--) begin
            spi_mosi = sh[i];
            repeat (4) @(negedge sys_clk);
            spi_sclk = 1'b1;
            rd[i] = spi_miso;
            repeat (4) @(negedge sys_clk);
            spi_sclk = 1'b0;
        end
        repeat (4) @(negedge sys_clk);
        spi_cs_n = 1'b1;
        // released data line must not keep looking valid
        spi_mosi = ~spi_mosi;
        rd_data = rd[7:0];
        rd_done = ~cmd[7];
        @(negedge sys_clk);
        rd_done = 1'b0;
        repeat (3) @(negedge sys_clk);
    endtask : xfer
endmodule : lcsr_host

/* File: bench/lcsr_properties.sv */
`timescale 1ns/1ps
module lcsr_properties (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic transmit_enable_pin,
    input wire logic line_high_det,
    input wire logic line_fault_det,
    input wire logic reg3v3_undervolt_det,
    input wire logic supply_undervolt_det,
    input wire logic overtemp_det,
    input wire logic reg3v3_monitor_enable,
    input wire logic irq_n,
    input wire logic undervoltage_out,
    input wire logic line_fault_status,
    input wire logic supply_undervolt_status,
    input wire logic overtemp_status,
    input wire logic line_driver_active,
    input wire logic receive_out
);
    // ==========================================
    // settle counter: $past must not reach into reset
    logic [2:0] age_ff;
    logic ok;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            age_ff <= 3'h0;
        end else if (age_ff != 3'h4) begin
            age_ff <= age_ff + 3'h1;
        end
    end
    assign ok = age_ff == 3'h4;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ==========================================
    // checks
    a_rx_level: assert property (ok && !$past(line_high_det, 3) |-> receive_out)
        else $error("receive_out low");
    a_drv_enable: assert property (ok && $past(transmit_enable_pin, 3) |-> line_driver_active)
        else $error("driver off");
    a_fault_copy: assert property (ok |-> line_fault_status == $past(line_fault_det, 3))
        else $error("fault status");
    a_supply_copy: assert property (ok |-> supply_undervolt_status == $past(supply_undervolt_det, 3))
        else $error("supply status");
    a_temp_copy: assert property (ok |-> overtemp_status == $past(overtemp_det, 3))
        else $error("temp status");
    a_uv_gated: assert property (ok && !$past(reg3v3_monitor_enable, 3) |-> !undervoltage_out)
        else $error("uv without monitor");
    a_uv_release: assert property (ok && !$past(reg3v3_undervolt_det, 3) |-> !undervoltage_out)
        else $error("uv not released");
    a_supply_irq: assert property (ok && $rose(supply_undervolt_det) |-> ##[1:6] !irq_n)
        else $error("no irq on supply");
    a_temp_irq: assert property (ok && $rose(overtemp_det) |-> ##[1:6] !irq_n)
        else $error("no irq on temp");
    a_irq_hold: assert property (line_fault_status [*3] |-> !irq_n)
        else $error("irq released");
    cover property (!irq_n ##1 irq_n);
    cover property (undervoltage_out);
    cover property (line_fault_status && !irq_n);
endmodule : lcsr_properties

bind lcsr_regs lcsr_properties chk_u (.*);

/* File: bench/line_config_status_regs_test.sv */
`timescale 1ns/1ps
module line_config_status_regs_test;
    import lcsr_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, rd_done;
    logic transmit_enable_pin, transmit_data_c, transmit_data_q, line_high_det;
    logic line_fault_det, reg3v3_undervolt_det, supply_undervolt_det, overtemp_det;
    logic reg3v3_monitor_enable, irq_n, undervoltage_out, line_fault_status;
    logic supply_undervolt_status, overtemp_status, filter_1mhz, fast_slew, line_sink_on;
    logic line_high_side_on, line_low_side_on, line_driver_active, receive_out;
    logic [7:0] rd_data;
    logic [7:0] cfg;
    logic [7:0] exp_q[$];
    int mismatches = 0;
    int samples_checked = 0;
    int seed = 32'h7496;
    always #50 sys_clk = ~sys_clk;
    lcsr_regs dut_u (.*);
    lcsr_host host_u (.*);
    // ==========================================
    // checking
    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    task automatic summarize;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize
    always @(posedge rd_done) begin
        if (exp_q.size() == 0) begin
            mismatches++;
            $display("[FAIL] read data expected none seen %h", rd_data);
        end else begin
            cmp("read data", exp_q.pop_front(), rd_data);
        end
    end
    function automatic logic [7:0] pexp(input logic [7:0] c, input logic i);
        logic on;
        logic lv;
        on = c[CFG_DRV_EN] | transmit_enable_pin;
        lv = (transmit_data_c & transmit_data_q) ? c[CFG_SOFT_LEVEL] : 1'b1;
        return {c[CFG_RX_FILTER], c[CFG_FAST_SLEW], on & lv & (c[CFG_PUSHPULL] | ~c[CFG_LOWSIDE]),
            on & ~lv & (c[CFG_PUSHPULL] | c[CFG_LOWSIDE]), on,
            c[CFG_RX_DISABLE] | ~line_high_det, c[CFG_SINK_EN], i};
    endfunction : pexp
    task automatic chk(input logic [7:0] c, input logic i);
        cmp("pins", pexp(c, i), {filter_1mhz, fast_slew, line_high_side_on, line_low_side_on,
            line_driver_active, receive_out, line_sink_on, irq_n});
    endtask : chk
    task automatic chk_sts(input logic [2:0] e);
        cmp("status pins", {5'h00, e}, {5'h00, line_fault_status, supply_undervolt_status,
            overtemp_status});
    endtask : chk_sts
    // ==========================================
    // register access
    task automatic wr(input logic [7:0] v);
        host_u.xfer({1'b1, 5'h00, ADDR_LINE_CONFIG}, v);
        repeat (4) @(negedge sys_clk);
    endtask : wr
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_u.xfer({6'h00, a}, 8'h00);
        repeat (4) @(negedge sys_clk);
    endtask : rd
    task automatic settle;
        repeat (6) @(negedge sys_clk);
    endtask : settle
    initial begin
        repeat (100000) @(posedge sys_clk);
        mismatches++;
        $display("[FAIL] run length expected done seen timeout");
        summarize();
    end
    // ==========================================
    // scenarios
    initial begin
        {transmit_enable_pin, transmit_data_c, transmit_data_q, line_high_det} = 4'h0;
        {line_fault_det, reg3v3_undervolt_det, supply_undervolt_det, overtemp_det} = 4'h0;
        reg3v3_monitor_enable = 1'b0;
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk(8'h00, 1'b1);
        rd(ADDR_LINE_CONFIG, LINE_CONFIG_RESET);
        rd(2'h2, 8'h00);
        for (int k = 0; k < 6; k++) begin
            cfg = (k == 0) ? 8'hFF : 8'($random(seed));
            transmit_enable_pin = k[0];
            {transmit_data_c, transmit_data_q} = 2'($random(seed));
            line_high_det = k[1];
            wr(cfg);
            chk(cfg, 1'b1);
            rd(ADDR_LINE_CONFIG, cfg);
            rd(ADDR_ALARM_STATUS, {3'h0, ~line_high_det, 4'h0});
        end
        host_u.xfer({1'b1, 5'h00, ADDR_ALARM_STATUS}, 8'hFF);
        repeat (4) @(negedge sys_clk);
        rd(ADDR_LINE_CONFIG, cfg);
        {transmit_enable_pin, line_high_det} = 2'h0;
        {transmit_data_c, transmit_data_q} = 2'h3;
        for (int k = 0; k < 8; k++) begin
            cfg = {2'h0, k[2], k[1], 1'b1, k[0], 2'h0};
            wr(cfg);
            chk(cfg, 1'b1);
        end
        line_fault_det = 1'b1;
        settle();
        chk(cfg, 1'b0);
        chk_sts(3'h4);
        rd(ADDR_ALARM_STATUS, 8'h18);
        rd(ADDR_ALARM_STATUS, 8'h18);
        line_fault_det = 1'b0;
        rd(ADDR_ALARM_STATUS, 8'h18);
        chk(cfg, 1'b1);
        supply_undervolt_det = 1'b1;
        settle();
        chk(cfg, 1'b0);
        chk_sts(3'h2);
        supply_undervolt_det = 1'b0;
        rd(ADDR_ALARM_STATUS, 8'h12);
        chk(cfg, 1'b1);
        reg3v3_undervolt_det = 1'b1;
        settle();
        chk(cfg, 1'b1);
        cmp("uv out", 8'h00, {7'h00, undervoltage_out});
        rd(ADDR_ALARM_STATUS, 8'h14);
        reg3v3_undervolt_det = 1'b0;
        reg3v3_monitor_enable = 1'b1;
        settle();
        reg3v3_undervolt_det = 1'b1;
        settle();
        chk(cfg, 1'b0);
        cmp("uv out", 8'h01, {7'h00, undervoltage_out});
        reg3v3_undervolt_det = 1'b0;
        settle();
        cmp("uv out", 8'h00, {7'h00, undervoltage_out});
        rd(ADDR_ALARM_STATUS, 8'h14);
        chk(cfg, 1'b1);
        overtemp_det = 1'b1;
        settle();
        chk(cfg, 1'b0);
        chk_sts(3'h1);
        rd(ADDR_ALARM_STATUS, 8'h11);
        rd(ADDR_ALARM_STATUS, 8'h10);
        chk(cfg, 1'b1);
        overtemp_det = 1'b0;
        settle();
        chk_sts(3'h0);
        overtemp_det = 1'b1;
        settle();
        rd(ADDR_ALARM_STATUS, 8'h11);
        if (exp_q.size() != 0) begin
            mismatches++;
            $display("[FAIL] pending reads expected 0 seen %0d", exp_q.size());
        end
        summarize();
    end
endmodule : line_config_status_regs_test

/* File: shared/lcsr_pkg.sv */
package lcsr_pkg;
    // ==========================================
    // register addresses (two address bits per frame)
    localparam int ADDR_W = 2;
    localparam logic [1:0] ADDR_ALARM_STATUS = 2'h0;
    localparam logic [1:0] ADDR_LINE_CONFIG = 2'h1;
    localparam logic [7:0] LINE_CONFIG_RESET = 8'h00;

    // ==========================================
    // line_config field positions
    localparam int CFG_RX_FILTER = 7;
    localparam int CFG_FAST_SLEW = 6;
    localparam int CFG_LOWSIDE = 5;
    localparam int CFG_PUSHPULL = 4;
    localparam int CFG_DRV_EN = 3;
    localparam int CFG_SOFT_LEVEL = 2;
    localparam int CFG_RX_DISABLE = 1;
    localparam int CFG_SINK_EN = 0;

    // ==========================================
    // alarm_status field positions
    localparam int STS_LEVEL_INV = 4;
    localparam int STS_LINE_FAULT = 3;
    localparam int STS_REG3V3_UV = 2;
    localparam int STS_SUPPLY_UV = 1;
    localparam int STS_OVERTEMP = 0;

    // ==========================================
    // serial frame: command byte {write, 5'b0, addr[1:0]} then data byte
    localparam int CMD_WRITE_BIT = 7;
    localparam logic [4:0] FRAME_CMD_BITS = 5'h08;
    localparam logic [4:0] FRAME_BITS = 5'h10;

    // ==========================================
    // pins that cross into sys_clk, index into the synchroniser bus
    localparam int IN_W = 12;
    localparam int IN_SCLK = 0;
    localparam int IN_CS_N = 1;
    localparam int IN_MOSI = 2;
    localparam int IN_TRANSMIT_ENABLE_PIN = 3;
    localparam int IN_TXC = 4;
    localparam int IN_TXQ = 5;
    localparam int IN_LINE_HIGH = 6;
    localparam int IN_LINE_FAULT = 7;
    localparam int IN_REG_UV = 8;
    localparam int IN_SUPPLY_UV = 9;
    localparam int IN_OVERTEMP = 10;
    localparam int IN_MON_EN = 11;
    // pin levels seen at reset: select, clock idle
    localparam logic [IN_W-1:0] IN_RESET = 12'h002;
endpackage : lcsr_pkg

/* File: src/lcsr_regs.sv */
`timescale 1ns/1ps
// Overview of operation
// RULE1 - status level bit is the line level inverted: 1 below 8V, 0 above 13V
// RULE2 - level bit tracks even with receiver off, never interrupts, unchanged by reads
// RULE3 - driver short or voltage fault sets line fault flag and status, pulls irq low
// RULE4 - status read clears line fault flag and releases irq
// RULE5 - regulator below 2.4V sets its flag; irq only when monitoring is enabled
// RULE6 - with monitoring, undervoltage output high while flag set, low once regulator recovers
// RULE7 - supply below 7.4V sets flag and status, pulls irq low, always active
// RULE8 - status read clears supply and regulator undervoltage flags and releases irq
// RULE9 - over 115C sets overtemp status and flag, irq asserted
// RULE10 - read clears overtemp flag; no re-set until temperature drops below 95C
// RULE11 - line config fully read/write, zero after power-on
// RULE12 - filter select: 500kHz at 0, 1MHz at 1, both receivers together
// RULE13 - fast slew speeds up both drivers; host sets it only for 230kbps
// RULE14 - open-drain: low-side select 1 sinks, 0 sources
// RULE15 - push-pull select 1 gives push-pull, 0 open-drain
// RULE16 - driver enabled when enable bit or transmit enable pin is high
// RULE17 - enabled and both data pins high: line follows soft level bit
// RULE18 - receiver disable switches receiver off and forces receive output high
// RULE19 - sink enable bit switches the line current sink on and off
// RULE20 - persisting line fault sets its flag again right after a status read
// RULE21 - irq stays low while any enabled flag is set
module lcsr_regs (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    input wire logic transmit_enable_pin,
    input wire logic transmit_data_c,
    input wire logic transmit_data_q,
    input wire logic line_high_det,
    input wire logic line_fault_det,
    input wire logic reg3v3_undervolt_det,
    input wire logic supply_undervolt_det,
    input wire logic overtemp_det,
    input wire logic reg3v3_monitor_enable,
    output logic irq_n,
    output logic undervoltage_out,
    output logic line_fault_status,
    output logic supply_undervolt_status,
    output logic overtemp_status,
    output logic filter_1mhz,
    output logic fast_slew,
    output logic line_high_side_on,
    output logic line_low_side_on,
    output logic line_driver_active,
    output logic receive_out,
    output logic line_sink_on
);
    import lcsr_pkg::*;

    // ==========================================
    // state
    typedef struct packed {
        logic [7:0] line_config;
        logic line_fault_irq_flag;
        logic reg3v3_undervolt_irq_flag;
        logic supply_undervolt_irq_flag;
        logic overtemp_irq_flag;
        logic reg_uv_prev;
        logic supply_uv_prev;
        logic overtemp_prev;
        logic sclk_prev;
        logic cs_n_prev;
        logic [7:0] rx_shift;
        logic [7:0] tx_shift;
        logic [4:0] bit_cnt;
        logic cmd_write;
        logic [ADDR_W-1:0] cmd_addr;
        logic [3:0] sts_snap;
        logic miso;
        logic irq_n;
        logic uv_out;
        logic lf_status;
        logic sup_status;
        logic ot_status;
        logic filt;
        logic slew;
        logic hi_on;
        logic lo_on;
        logic drv_active;
        logic rx_out;
        logic sink_on;
    } lcsr_st_t;

    lcsr_st_t st_ff;
    lcsr_st_t nxt_st;
    logic [IN_W-1:0] pin_s;
    logic [IN_W-1:0] pin_raw;

    // ==========================================
    // synchronise every pin, including the serial clock
    assign pin_raw[IN_SCLK] = spi_sclk;
    assign pin_raw[IN_CS_N] = spi_cs_n;
    assign pin_raw[IN_MOSI] = spi_mosi;
    assign pin_raw[IN_TRANSMIT_ENABLE_PIN] = transmit_enable_pin;
    assign pin_raw[IN_TXC] = transmit_data_c;
    assign pin_raw[IN_TXQ] = transmit_data_q;
    assign pin_raw[IN_LINE_HIGH] = line_high_det;
    assign pin_raw[IN_LINE_FAULT] = line_fault_det;
    assign pin_raw[IN_REG_UV] = reg3v3_undervolt_det;
    assign pin_raw[IN_SUPPLY_UV] = supply_undervolt_det;
    assign pin_raw[IN_OVERTEMP] = overtemp_det;
    assign pin_raw[IN_MON_EN] = reg3v3_monitor_enable;

    // serial pins and slow line monitors run through separate but identical chains
    lcsr_sync #(
        .W(IN_TRANSMIT_ENABLE_PIN),
        .INIT(IN_RESET[IN_TRANSMIT_ENABLE_PIN-1:0])
    ) u_sync_serial (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in(pin_raw[IN_TRANSMIT_ENABLE_PIN-1:0]),
        .sync_out(pin_s[IN_TRANSMIT_ENABLE_PIN-1:0])
    );

    lcsr_sync #(
        .W(IN_W - IN_TRANSMIT_ENABLE_PIN),
        .INIT(IN_RESET[IN_W-1:IN_TRANSMIT_ENABLE_PIN])
    ) u_sync_line (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in(pin_raw[IN_W-1:IN_TRANSMIT_ENABLE_PIN]),
        .sync_out(pin_s[IN_W-1:IN_TRANSMIT_ENABLE_PIN])
    );

    // ==========================================
    // next state
    always_comb begin
        logic sclk_rise;
        logic sclk_fall;
        logic cs_rise;
        logic status_clear;
        logic drv_en;
        logic level;
        logic [7:0] rd_data;
        logic [4:0] cnt_inc;
        logic irq_any;
        nxt_st = st_ff;
        drv_en = 1'b0;
        level = 1'b0;
        irq_any = 1'b0;
        sclk_rise = pin_s[IN_SCLK] & ~st_ff.sclk_prev & ~pin_s[IN_CS_N];
        sclk_fall = ~pin_s[IN_SCLK] & st_ff.sclk_prev & ~pin_s[IN_CS_N];
        cs_rise = pin_s[IN_CS_N] & ~st_ff.cs_n_prev;
        status_clear = 1'b0;
        cnt_inc = st_ff.bit_cnt + 5'h01;
        rd_data = 8'h00;
        nxt_st.sclk_prev = pin_s[IN_SCLK];
        nxt_st.cs_n_prev = pin_s[IN_CS_N];

        // status word; the level bit is live and never latched
        if (st_ff.rx_shift[ADDR_W-1:0] == ADDR_ALARM_STATUS) begin
            rd_data[STS_LEVEL_INV] = ~pin_s[IN_LINE_HIGH]; // RULE1 RULE2
            rd_data[STS_LINE_FAULT] = st_ff.line_fault_irq_flag;
            rd_data[STS_REG3V3_UV] = st_ff.reg3v3_undervolt_irq_flag;
            rd_data[STS_SUPPLY_UV] = st_ff.supply_undervolt_irq_flag;
            rd_data[STS_OVERTEMP] = st_ff.overtemp_irq_flag;
        end else if (st_ff.rx_shift[ADDR_W-1:0] == ADDR_LINE_CONFIG) begin
            rd_data = st_ff.line_config; // RULE11
        end else begin
            // the two registers outside this block read back as zero
            rd_data = 8'h00;
        end

        // ==========================================
        // serial frame, mode 0: sample on rise, shift out on fall
        // sclk is oversampled, so each of its phases must last three system clocks
        if (pin_s[IN_CS_N]) begin
            nxt_st.bit_cnt = 5'h00;
            nxt_st.miso = 1'b0;
        end else if (sclk_rise && st_ff.bit_cnt != FRAME_BITS) begin
            nxt_st.rx_shift = {st_ff.rx_shift[6:0], pin_s[IN_MOSI]};
            nxt_st.bit_cnt = cnt_inc;
            if (cnt_inc == FRAME_CMD_BITS) begin
                nxt_st.cmd_write = st_ff.rx_shift[CMD_WRITE_BIT-1];
                nxt_st.cmd_addr = {st_ff.rx_shift[0], pin_s[IN_MOSI]};
            end
            if (cnt_inc == FRAME_BITS && st_ff.cmd_write
                    && st_ff.cmd_addr == ADDR_LINE_CONFIG) begin
                nxt_st.line_config = {st_ff.rx_shift[6:0], pin_s[IN_MOSI]}; // RULE11
            end
        end else if (sclk_fall && st_ff.bit_cnt == FRAME_CMD_BITS) begin
            // read data is chosen only after the whole address is in
            nxt_st.miso = rd_data[7];
            nxt_st.tx_shift = {rd_data[6:0], 1'b0};
            nxt_st.sts_snap = rd_data[STS_LINE_FAULT:STS_OVERTEMP];
        end else if (sclk_fall && st_ff.bit_cnt > FRAME_CMD_BITS) begin
            nxt_st.miso = st_ff.tx_shift[7];
            nxt_st.tx_shift = {st_ff.tx_shift[6:0], 1'b0};
        end

        // a completed read frame of the status register clears the flags
        if (cs_rise && st_ff.bit_cnt == FRAME_BITS && !st_ff.cmd_write
                && st_ff.cmd_addr == ADDR_ALARM_STATUS) begin
            status_clear = 1'b1; // RULE4 RULE8 RULE10
        end

        // ==========================================
        // alarm flags: a set in the clearing cycle wins
        nxt_st.reg_uv_prev = pin_s[IN_REG_UV];
        nxt_st.supply_uv_prev = pin_s[IN_SUPPLY_UV];
        nxt_st.overtemp_prev = pin_s[IN_OVERTEMP];
        // only flags that went out in the word are cleared, so later events survive
        nxt_st.line_fault_irq_flag = (st_ff.line_fault_irq_flag
            & ~(status_clear & st_ff.sts_snap[STS_LINE_FAULT]))
            | pin_s[IN_LINE_FAULT]; // RULE3 RULE20
        nxt_st.reg3v3_undervolt_irq_flag = (st_ff.reg3v3_undervolt_irq_flag
            & ~(status_clear & st_ff.sts_snap[STS_REG3V3_UV]))
            | (pin_s[IN_REG_UV] & ~st_ff.reg_uv_prev); // RULE5
        nxt_st.supply_undervolt_irq_flag = (st_ff.supply_undervolt_irq_flag
            & ~(status_clear & st_ff.sts_snap[STS_SUPPLY_UV]))
            | (pin_s[IN_SUPPLY_UV] & ~st_ff.supply_uv_prev); // RULE7
        // the warning detector only falls at 95C, so an edge means a fresh event
        nxt_st.overtemp_irq_flag = (st_ff.overtemp_irq_flag
            & ~(status_clear & st_ff.sts_snap[STS_OVERTEMP]))
            | (pin_s[IN_OVERTEMP] & ~st_ff.overtemp_prev); // RULE9 RULE10
        nxt_st.lf_status = pin_s[IN_LINE_FAULT]; // RULE3
        nxt_st.sup_status = pin_s[IN_SUPPLY_UV]; // RULE7
        nxt_st.ot_status = pin_s[IN_OVERTEMP]; // RULE9

        // the level bit is left out on purpose: it never raises an interrupt
        irq_any = nxt_st.line_fault_irq_flag | nxt_st.supply_undervolt_irq_flag; // RULE3 RULE7
        irq_any = irq_any | nxt_st.overtemp_irq_flag; // RULE9
        // the regulator flag is always recorded but only interrupts when monitored
        irq_any = irq_any | (nxt_st.reg3v3_undervolt_irq_flag & pin_s[IN_MON_EN]); // RULE5
        nxt_st.irq_n = ~irq_any; // RULE21 RULE2
        nxt_st.uv_out = pin_s[IN_MON_EN] & nxt_st.reg3v3_undervolt_irq_flag
            & pin_s[IN_REG_UV]; // RULE6

        // ==========================================
        // line driver and receiver controls
        drv_en = st_ff.line_config[CFG_DRV_EN] | pin_s[IN_TRANSMIT_ENABLE_PIN]; // RULE16
        // data pins low drive the line high; both high hand it to the soft bit
        level = (pin_s[IN_TXC] & pin_s[IN_TXQ]) ? st_ff.line_config[CFG_SOFT_LEVEL]
            : 1'b1; // RULE17
        nxt_st.drv_active = drv_en;
        if (st_ff.line_config[CFG_PUSHPULL]) begin
            nxt_st.hi_on = drv_en & level; // RULE15
            nxt_st.lo_on = drv_en & ~level;
        end else if (st_ff.line_config[CFG_LOWSIDE]) begin
            nxt_st.hi_on = 1'b0; // RULE14
            nxt_st.lo_on = drv_en & ~level;
        end else begin
            nxt_st.hi_on = drv_en & level; // RULE14
            nxt_st.lo_on = 1'b0;
        end
        nxt_st.filt = st_ff.line_config[CFG_RX_FILTER]; // RULE12
        nxt_st.slew = st_ff.line_config[CFG_FAST_SLEW]; // RULE13
        nxt_st.rx_out = st_ff.line_config[CFG_RX_DISABLE] | ~pin_s[IN_LINE_HIGH]; // RULE18
        nxt_st.sink_on = st_ff.line_config[CFG_SINK_EN]; // RULE19
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_ff.line_config <= LINE_CONFIG_RESET;
            st_ff.line_fault_irq_flag <= 1'b0;
            st_ff.reg3v3_undervolt_irq_flag <= 1'b0;
            st_ff.supply_undervolt_irq_flag <= 1'b0;
            st_ff.overtemp_irq_flag <= 1'b0;
            st_ff.reg_uv_prev <= IN_RESET[IN_REG_UV];
            st_ff.supply_uv_prev <= IN_RESET[IN_SUPPLY_UV];
            st_ff.overtemp_prev <= IN_RESET[IN_OVERTEMP];
            st_ff.sclk_prev <= IN_RESET[IN_SCLK];
            st_ff.cs_n_prev <= IN_RESET[IN_CS_N];
            st_ff.rx_shift <= 8'h00;
            st_ff.tx_shift <= 8'h00;
            st_ff.bit_cnt <= 5'h00;
            st_ff.cmd_write <= 1'b0;
            st_ff.cmd_addr <= ADDR_ALARM_STATUS;
            st_ff.sts_snap <= 4'h0;
            st_ff.miso <= 1'b0;
            st_ff.irq_n <= 1'b1;
            st_ff.uv_out <= 1'b0;
            st_ff.lf_status <= 1'b0;
            st_ff.sup_status <= 1'b0;
            st_ff.ot_status <= 1'b0;
            st_ff.filt <= 1'b0;
            st_ff.slew <= 1'b0;
            st_ff.hi_on <= 1'b0;
            st_ff.lo_on <= 1'b0;
            st_ff.drv_active <= 1'b0;
            st_ff.rx_out <= 1'b1;
            st_ff.sink_on <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================
    // outputs, each straight from a flop
    assign spi_miso = st_ff.miso;
    assign irq_n = st_ff.irq_n;
    assign undervoltage_out = st_ff.uv_out;
    assign line_fault_status = st_ff.lf_status;
    assign supply_undervolt_status = st_ff.sup_status;
    assign overtemp_status = st_ff.ot_status;
    assign filter_1mhz = st_ff.filt;
    assign fast_slew = st_ff.slew;
    assign line_high_side_on = st_ff.hi_on;
    assign line_low_side_on = st_ff.lo_on;
    assign line_driver_active = st_ff.drv_active;
    assign receive_out = st_ff.rx_out;
    assign line_sink_on = st_ff.sink_on;
endmodule : lcsr_regs

/* File: src/lcsr_sync.sv */
`timescale 1ns/1ps
module lcsr_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } lcsr_sync_st_t;

    lcsr_sync_st_t st_ff;
    lcsr_sync_st_t nxt_st;

    // the first stage is read only by the second stage
    always_comb begin
        nxt_st = st_ff;
        nxt_st.meta = async_in;
        nxt_st.stable = st_ff.meta;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_ff <= {INIT, INIT};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sync_out = st_ff.stable;
endmodule : lcsr_sync
